// ---- src/moie_consts.svh ----
`ifndef MOIE_CONSTS_SVH
`define MOIE_CONSTS_SVH
// Register map (byte addresses)
`define MOIE_OFF_CTRL 12'h000
`define MOIE_OFF_INSTR 12'h004
`define MOIE_OFF_ACC 12'h008
`define MOIE_OFF_STATUS 12'h00C
`define MOIE_OFF_MEM 12'h200
// Field positions
`define MOIE_CTRL_GO 0
`define MOIE_STAT_ZERO 0
`define MOIE_STAT_BUSY 1
`define MOIE_INSTR_DEST 7
// Opcode field [13:8]; load immediate decodes only [13:10], so [9:8] are free
`define MOIE_OP_OR 6'h04
`define MOIE_OP_COPY 6'h08
`define MOIE_OP_STORE_IDLE 6'h00
`define MOIE_OP_LOAD_IMM 4'hC
// Reset value, memory depth and execution cycles
`define MOIE_ACC_RST 8'h00
`define MOIE_MEM_WORDS 128
`define MOIE_EXEC_CYCLES 1
`endif

// ---- src/moie_pkg.sv ----
package moie_pkg;
  typedef enum logic [2:0] {
    MOIE_IDLE_INSTRUCTION,
    MOIE_OR_ACC_INTO_OPERAND,
    MOIE_COPY_OPERAND,
    MOIE_STORE_ACC,
    MOIE_LOAD_IMMEDIATE,
    MOIE_UNKNOWN
  } moie_op_t;
  typedef struct packed {
    moie_op_t op;
    logic dest;
    logic [6:0] addr;
    logic [7:0] imm;
  } moie_dec_t;
  typedef struct packed {
    logic acc_we;
    logic [7:0] acc_val;
    logic mem_we;
    logic [6:0] mem_addr;
    logic [7:0] mem_val;
    logic zero_we;
    logic zero_val;
  } moie_wb_t;
endpackage

// ---- src/moie_exec_unit.sv ----
`include "moie_consts.svh"
// Combinational decode and execute of one instruction word
module moie_exec_unit
  import moie_pkg::*;
(
  input wire logic [13:0] instr, // Instruction word
  input wire logic [7:0] acc, // Accumulator value
  input wire logic [7:0] operand, // Addressed memory value
  output moie_wb_t wb, // Write-back set
  output moie_dec_t dec // Decoded fields
);
  // Field decode used for both read address and execution
  function automatic moie_dec_t decode(input logic [13:0] w);
    moie_dec_t d;
    d.dest = w[`MOIE_INSTR_DEST];
    d.addr = w[6:0];
    d.imm = w[7:0];
    d.op = MOIE_UNKNOWN;
    if (w[13:8] == `MOIE_OP_OR) d.op = MOIE_OR_ACC_INTO_OPERAND;
    else if (w[13:8] == `MOIE_OP_COPY) d.op = MOIE_COPY_OPERAND;
    else if (w[13:10] == `MOIE_OP_LOAD_IMM) d.op = MOIE_LOAD_IMMEDIATE; // don't-care bits ignored
    else if (w[13:8] == `MOIE_OP_STORE_IDLE && w[7]) d.op = MOIE_STORE_ACC;
    else if (w[13:7] == 7'h00 && w[4:0] == 5'h00) d.op = MOIE_IDLE_INSTRUCTION;
    return d;
  endfunction

  logic [7:0] result;
  assign dec = decode(instr);

  // Result and write-back selection
  always_comb begin
    wb = '0;
    result = 8'h00;
    wb.mem_addr = dec.addr;
    unique case (dec.op)
      MOIE_OR_ACC_INTO_OPERAND: begin
        result = acc | operand;
        wb.zero_we = 1'b1;
      end
      MOIE_COPY_OPERAND: begin
        result = operand;
        wb.zero_we = 1'b1;
      end
      MOIE_STORE_ACC: begin
        wb.mem_we = 1'b1;
        wb.mem_val = acc;
      end
      MOIE_LOAD_IMMEDIATE: begin
        wb.acc_we = 1'b1;
        wb.acc_val = dec.imm;
      end
      MOIE_IDLE_INSTRUCTION, MOIE_UNKNOWN: ;
    endcase
    if (dec.op == MOIE_OR_ACC_INTO_OPERAND || dec.op == MOIE_COPY_OPERAND) begin
      wb.zero_val = (result == 8'h00);
      wb.acc_we = ~dec.dest;
      wb.acc_val = result;
      wb.mem_we = dec.dest;
      wb.mem_val = result;
    end
  end
endmodule

// ---- src/moie_core.sv ----
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`include "moie_consts.svh"
// Contract
// - OR-into-operand forms accumulator OR operand and updates the zero flag.
// - Target bit 0 writes accumulator, 1 writes the addressed register back.
// - Copy-operand moves register to target, sets zero flag; one word, one cycle.
// - Copy with target 1 rewrites register unchanged and still updates zero.
// - Store-accumulator writes accumulator to register, flags unchanged, one cycle.
// - Load-immediate puts 8-bit immediate in accumulator, flags unchanged, one cycle.
module moie_core
  import moie_pkg::*;
(
  input wire logic aclk, // Clock, 250 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  typedef struct packed {
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [13:0] instr;
    logic [7:0] acc;
    logic zero;
    logic busy;
    logic done;
  } moie_state_t;

  moie_state_t st, next_st;
  logic [7:0] mem [0:`MOIE_MEM_WORDS-1];
  moie_wb_t wb;
  moie_dec_t dec;
  logic wr_fire, exec_go, mem_sw_we;
  logic [6:0] sw_idx;

  // --------------------------------------------------------------------
  // Execution unit
  // --------------------------------------------------------------------
  moie_exec_unit u_exec (
    .instr(st.instr),
    .acc(st.acc),
    .operand(mem[dec.addr]),
    .wb(wb),
    .dec(dec)
  );

  // --------------------------------------------------------------------
  // Bus channels
  // --------------------------------------------------------------------
  // Bus handshakes are combinational off the capture flags
  assign s_axi_awready = ~st.aw_got & ~st.bvalid;
  assign s_axi_wready = ~st.w_got & ~st.bvalid;
  assign s_axi_arready = ~st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign wr_fire = st.aw_got & st.w_got & ~st.bvalid;
  assign exec_go = wr_fire && st.aw_addr == `MOIE_OFF_CTRL && st.w_strb[0] && st.w_data[`MOIE_CTRL_GO];
  assign sw_idx = st.aw_addr[8:2];
  assign mem_sw_we = wr_fire && st.aw_addr[11:9] == 3'h1 && st.w_strb[0] && ~st.busy;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    // Address and data are captured on their own; either may come first
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    // Register writes; the map is small so decode is flat
    // Instr, acc and memory writes are dropped while busy, so the operand cannot move mid-run
    // Unmapped offsets answer SLVERR and change nothing
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'b00;
      if (st.aw_addr == `MOIE_OFF_INSTR && !st.busy) begin
        if (st.w_strb[0]) next_st.instr[7:0] = st.w_data[7:0];
        if (st.w_strb[1]) next_st.instr[13:8] = st.w_data[13:8];
      end else if (st.aw_addr == `MOIE_OFF_ACC && !st.busy) begin
        if (st.w_strb[0]) next_st.acc = st.w_data[7:0];
      end else if (exec_go) begin
        next_st.busy = 1'b1;
      end else if (st.aw_addr != `MOIE_OFF_CTRL && st.aw_addr != `MOIE_OFF_STATUS
                   && st.aw_addr[11:9] != 3'h1 && st.aw_addr != `MOIE_OFF_INSTR
                   && st.aw_addr != `MOIE_OFF_ACC) begin
        next_st.bresp = 2'b10;
      end
    end
    // Response holds until the master takes it
    if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
    // Execute the loaded word in a single cycle
    if (st.busy) begin
      if (wb.acc_we) next_st.acc = wb.acc_val;
      if (wb.zero_we) next_st.zero = wb.zero_val;
      next_st.busy = 1'b0;
      next_st.done = 1'b1;
    end
    // Read channel
    // Control reads as zero; unknown offsets answer SLVERR with zero data
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'b00;
      next_st.rdata = 32'h0000_0000;
      if (s_axi_araddr[11:0] == `MOIE_OFF_INSTR) next_st.rdata[13:0] = st.instr;
      else if (s_axi_araddr[11:0] == `MOIE_OFF_ACC) next_st.rdata[7:0] = st.acc;
      else if (s_axi_araddr[11:0] == `MOIE_OFF_STATUS) begin
        next_st.rdata[`MOIE_STAT_ZERO] = st.zero;
        next_st.rdata[`MOIE_STAT_BUSY] = st.busy;
      end else if (s_axi_araddr[11:9] == 3'h1) next_st.rdata[7:0] = mem[s_axi_araddr[8:2]];
      else if (s_axi_araddr[11:0] != `MOIE_OFF_CTRL) next_st.rresp = 2'b10;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.acc <= `MOIE_ACC_RST;
    end else begin
      st <= next_st;
    end
  end

  // Data memory; execution write-back beats software since busy blocks software writes
  always_ff @(posedge aclk) begin
    if (st.busy && wb.mem_we) mem[wb.mem_addr] <= wb.mem_val;
    else if (mem_sw_we) mem[sw_idx] <= st.w_data[7:0];
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  or_zero_a: assert property (st.busy && dec.op == MOIE_OR_ACC_INTO_OPERAND
    |=> st.zero == (($past(st.acc) | $past(mem[dec.addr])) == 8'h00))
    else $error("or zero flag wrong");
  dest_acc_a: assert property (st.busy && dec.op == MOIE_OR_ACC_INTO_OPERAND && !dec.dest
    |=> st.acc == ($past(st.acc) | $past(mem[dec.addr])))
    else $error("or result not in accumulator");
  dest_mem_keeps_acc_a: assert property (st.busy && dec.op == MOIE_OR_ACC_INTO_OPERAND && dec.dest
    |=> st.acc == $past(st.acc))
    else $error("accumulator changed for memory target");
  copy_acc_a: assert property (st.busy && dec.op == MOIE_COPY_OPERAND && !dec.dest
    |=> st.acc == $past(mem[dec.addr]) && st.done)
    else $error("copy operand wrong");
  copy_test_a: assert property (st.busy && dec.op == MOIE_COPY_OPERAND && dec.dest
    |=> st.zero == ($past(mem[dec.addr]) == 8'h00) && st.acc == $past(st.acc))
    else $error("copy test wrong");
  store_flags_a: assert property (st.busy && dec.op == MOIE_STORE_ACC
    |=> $stable(st.zero) && $stable(st.acc) && !st.busy)
    else $error("store changed flags");
  load_imm_a: assert property (st.busy && dec.op == MOIE_LOAD_IMMEDIATE
    |=> st.acc == $past(st.instr[7:0]) && $stable(st.zero))
    else $error("load immediate wrong");
  idle_quiet_a: assert property (st.busy && dec.op == MOIE_IDLE_INSTRUCTION
    |=> $stable(st.acc) && $stable(st.zero) && st.done)
    else $error("idle changed state");
  // The data array is never reset, so these only look at words a scenario wrote first
  or_to_mem_a: assert property (st.busy && dec.op == MOIE_OR_ACC_INTO_OPERAND && dec.dest
    |=> mem[dec.addr] == ($past(st.acc) | $past(mem[dec.addr])))
    else $error("or result not in register");
  or_keeps_mem_a: assert property (st.busy && dec.op == MOIE_OR_ACC_INTO_OPERAND && !dec.dest
    |=> mem[dec.addr] == $past(mem[dec.addr]))
    else $error("register changed for accumulator target");
  copy_self_mem_a: assert property (st.busy && dec.op == MOIE_COPY_OPERAND && dec.dest
    |=> mem[dec.addr] == $past(mem[dec.addr]))
    else $error("copy to self altered register");
  store_mem_a: assert property (st.busy && dec.op == MOIE_STORE_ACC
    |=> mem[dec.addr] == $past(st.acc))
    else $error("store did not reach register");
  exec_done_a: assert property (st.busy |=> !st.busy && st.done)
    else $error("execution took more than one cycle");
  or_cov: cover property (st.busy && dec.op == MOIE_OR_ACC_INTO_OPERAND);
  copy_cov: cover property (st.busy && dec.op == MOIE_COPY_OPERAND && dec.dest);
  store_cov: cover property (st.busy && dec.op == MOIE_STORE_ACC);
  load_cov: cover property (st.busy && dec.op == MOIE_LOAD_IMMEDIATE);
  idle_cov: cover property (st.busy && dec.op == MOIE_IDLE_INSTRUCTION);
endmodule

// ---- test/move_or_instruction_exec_tb.sv ----
`include "moie_consts.svh"
module move_or_instruction_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_errors = 0, tests_run = 0, cyc = 0;
  moie_core moie_core_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  always #2 aclk = ~aclk;
  // Every test is a few dozen cycles, so this ceiling only trips on a hang
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ----------------------------------------
  // Bus master tasks
  // ----------------------------------------
  // Answers are read at the rising edge itself, before the design's registers move on it
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_ok, w_ok;
    @(posedge aclk);
    awaddr <= {20'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= {20'h0, a};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic put(input logic [11:0] a, input logic [7:0] v);
    logic [1:0] r;
    wr(a, {24'h0, v}, r);
  endtask
  task automatic rc(input string what, input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, {24'h0, d[7:0]}, {24'h0, exp});
  endtask
  // Load the word, start it and poll busy until it drops
  task automatic exec(input logic [13:0] ins);
    logic [31:0] d;
    logic [1:0] r;
    wr(`MOIE_OFF_INSTR, {18'h0, ins}, r);
    wr(`MOIE_OFF_CTRL, 32'h1, r);
    do rd(`MOIE_OFF_STATUS, d, r); while (d[`MOIE_STAT_BUSY] !== 1'b0);
  endtask
  function automatic logic [11:0] mem(input logic [6:0] f);
    return 12'(`MOIE_OFF_MEM + f * 4);
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_copy_acc();
    put(mem(7'd6), 8'h00);
    put(`MOIE_OFF_ACC, 8'h55);
    exec({`MOIE_OP_COPY, 1'b0, 7'd6});
    rc("copy acc", `MOIE_OFF_ACC, 8'h00);
    rc("copy zero", `MOIE_OFF_STATUS, 8'h01);
    $display("copy to acc done");
  endtask
  // Zero stands at 1 here, so a load that touched it would show
  task automatic t_load_store();
    exec({`MOIE_OP_LOAD_IMM, 2'b00, 8'hA5});
    rc("load acc", `MOIE_OFF_ACC, 8'hA5);
    rc("load zero", `MOIE_OFF_STATUS, 8'h01);
    exec({`MOIE_OP_STORE_IDLE, 1'b1, 7'd5});
    rc("store mem", mem(7'd5), 8'hA5);
    rc("store zero", `MOIE_OFF_STATUS, 8'h01);
    $display("load and store done");
  endtask
  task automatic t_copy_self_idle();
    put(mem(7'd7), 8'h3C);
    exec({`MOIE_OP_COPY, 1'b1, 7'd7});
    rc("self mem", mem(7'd7), 8'h3C);
    rc("self acc", `MOIE_OFF_ACC, 8'hA5);
    rc("self zero", `MOIE_OFF_STATUS, 8'h00);
    exec(14'h0000);
    rc("idle acc", `MOIE_OFF_ACC, 8'hA5);
    rc("idle mem", mem(7'd7), 8'h3C);
    rc("idle zero", `MOIE_OFF_STATUS, 8'h00);
    $display("copy to self and idle done");
  endtask
  task automatic t_or();
    put(`MOIE_OFF_ACC, 8'h00);
    put(mem(7'd9), 8'h00);
    exec({`MOIE_OP_OR, 1'b0, 7'd9});
    rc("or zero", `MOIE_OFF_STATUS, 8'h01);
    put(mem(7'd9), 8'h24);
    exec({`MOIE_OP_OR, 1'b0, 7'd9});
    rc("or acc", `MOIE_OFF_ACC, 8'h24);
    rc("or clears zero", `MOIE_OFF_STATUS, 8'h00);
    put(`MOIE_OFF_ACC, 8'h81);
    put(mem(7'd127), 8'h18);
    exec({`MOIE_OP_OR, 1'b1, 7'd127});
    rc("or mem", mem(7'd127), 8'h99);
    rc("or acc kept", `MOIE_OFF_ACC, 8'h81);
    rc("or nonzero", `MOIE_OFF_STATUS, 8'h00);
    $display("or into operand done");
  endtask
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    rd(12'h100, d, r);
    chk("read resp", {30'h0, r}, 32'h2);
    wr(12'h100, 32'h0, r);
    chk("write resp", {30'h0, r}, 32'h2);
    $display("unmapped access done");
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc("reset acc", `MOIE_OFF_ACC, 8'h00);
    t_copy_acc();
    t_load_store();
    t_copy_self_idle();
    t_or();
    t_unmapped();
    tally_and_finish();
  end
endmodule
